// ---- sarro_pkg.sv ----
// Constants and types shared by both ends of the serial converter readout link
package sarro_pkg;
	localparam int unsigned CNT_W = 5;
	localparam int unsigned FRAME_BITS = 16;
	localparam int unsigned LEAD_ZEROS = 2;
	localparam logic [CNT_W-1:0] FRAME_EDGES = 5'h10;
	localparam logic [CNT_W-1:0] GLITCH_EDGES = 5'h02;
	localparam logic [CNT_W-1:0] PD_EDGES = 5'h0a;
	// Host clock divider timing
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned SCLK_PERIOD_NS = 400;
	localparam int unsigned QUIET_NS = 100;
	localparam int unsigned DIV_W = 4;
	localparam logic [DIV_W-1:0] HALF_CYCLES = DIV_W'(SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS));
	localparam logic [DIV_W-1:0] QUIET_CYCLES =
		DIV_W'((QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// Select lead before the first fall: one serial clock period
	localparam logic [DIV_W-1:0] LEAD_CYCLES = DIV_W'(SCLK_PERIOD_NS / CLK_PERIOD_NS);
	typedef enum logic [1:0] {
		SARRO_PWR_NORMAL,
		SARRO_PWR_PARTIAL,
		SARRO_PWR_FULL
	} sarro_power_type;
endpackage

// ---- sarro_link_if.sv ----
// Link between converter end and host end
`timescale 1ns/10ps
`default_nettype none
interface sarro_link_if;
	logic conv_sel_b;
	logic ser_clk;
	logic serial_result_out;
	logic serial_result_oe;
	logic line_level;
	// Released line reads high through a pull-up
	assign line_level = serial_result_oe ? serial_result_out : 1'b1;
	modport adc (
		input conv_sel_b,
		input ser_clk,
		output serial_result_out,
		output serial_result_oe
	);
	modport host (
		output conv_sel_b,
		output ser_clk,
		input line_level
	);
endinterface
`default_nettype wire

// ---- sarro_adc_end.sv ----
// Converter end: conversion sequencing, serial shift-out and power modes
`timescale 1ns/10ps
`default_nettype none
// Pin sampler: settles an outside pin and finds its edges
module sarro_pin_sync #(
	parameter logic IDLE_LEVEL = 1'b1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic pin,
	output logic fall,
	output logic rise
);
	logic stage1;
	logic stage2;
	logic stage3;

	// Two settling flops, a third for edges; idle reset avoids false edges
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stage1 <= IDLE_LEVEL;
			stage2 <= IDLE_LEVEL;
			stage3 <= IDLE_LEVEL;
		end else begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Edges taken from settled samples only
	assign fall = stage3 & ~stage2;
	assign rise = ~stage3 & stage2;
endmodule // sarro_pin_sync

module sarro_adc_end #(
	parameter int unsigned RES_BITS = 12
) (
	input wire logic clk,
	input wire logic rst_b,
	sarro_link_if.adc link,
	input wire logic [RES_BITS-1:0] analog_level,
	output logic [RES_BITS-1:0] result_data,
	output logic result_valid,
	output logic tracking,
	output logic frame_active,
	output sarro_pkg::sarro_power_type power_mode
);
	// Counts derived from the result width
	localparam logic [sarro_pkg::CNT_W-1:0] CONV_EDGES =
		sarro_pkg::CNT_W'(RES_BITS + 2);
	localparam logic [sarro_pkg::CNT_W-1:0] TRACK_EDGES =
		sarro_pkg::CNT_W'(RES_BITS + 1);
	localparam int unsigned TRAIL_ZEROS =
		sarro_pkg::FRAME_BITS - sarro_pkg::LEAD_ZEROS - RES_BITS;

	// Link pins pass two flops before any logic sees them
	logic sel_fall;
	logic sel_rise;
	logic sck_fall;
	logic sck_rise;

	// Select pin, idles high
	sarro_pin_sync #(
		.IDLE_LEVEL(1'b1)
	) u_sarro_pin_sync_sel (
		.clk(clk),
		.rst_b(rst_b),
		.pin(link.conv_sel_b),
		.fall(sel_fall),
		.rise(sel_rise)
	);

	// Serial clock pin, idles high
	sarro_pin_sync #(
		.IDLE_LEVEL(1'b1)
	) u_sarro_pin_sync_sck (
		.clk(clk),
		.rst_b(rst_b),
		.pin(link.ser_clk),
		.fall(sck_fall),
		.rise(sck_rise)
	);

	// Frame state
	logic [sarro_pkg::FRAME_BITS-1:0] shreg;
	logic [sarro_pkg::CNT_W-1:0] edge_cnt;
	logic [RES_BITS-1:0] held_level;
	logic waking;
	logic dout;
	logic dout_oe;
	logic [sarro_pkg::FRAME_BITS-1:0] next_shreg;
	logic [sarro_pkg::CNT_W-1:0] next_edge_cnt;
	logic [RES_BITS-1:0] next_held_level;
	logic next_waking;
	logic next_dout;
	logic next_dout_oe;
	logic next_frame_active;
	logic next_tracking;
	logic [RES_BITS-1:0] next_result_data;
	logic next_result_valid;
	sarro_pkg::sarro_power_type next_power_mode;
	logic [sarro_pkg::CNT_W-1:0] edge_inc;

	assign edge_inc = edge_cnt + sarro_pkg::CNT_W'(1);

	// Next-state computation for the whole frame sequencer
	always_comb begin
		next_shreg = shreg;
		next_edge_cnt = edge_cnt;
		next_held_level = held_level;
		next_waking = waking;
		next_dout = dout;
		next_dout_oe = dout_oe;
		next_frame_active = frame_active;
		next_tracking = tracking;
		next_result_data = result_data;
		next_result_valid = 1'b0;
		next_power_mode = power_mode;
		if (sel_rise) begin
			// Select high: release line, back to track
			next_dout_oe = 1'b0;
			next_frame_active = 1'b0;
			next_tracking = 1'b1;
			if (frame_active) begin
				// Wake frame: long one powers up, short one powers fully down
				if (waking) begin
					next_waking = 1'b0;
					if (edge_cnt >= sarro_pkg::PD_EDGES) begin
						next_power_mode = sarro_pkg::SARRO_PWR_NORMAL;
					end else begin
						next_power_mode = sarro_pkg::SARRO_PWR_FULL;
					end
				end else if (edge_cnt < CONV_EDGES) begin
					// Conversion cut short: aborted, line released by this select rise
					if (edge_cnt >= sarro_pkg::GLITCH_EDGES &&
						edge_cnt < sarro_pkg::PD_EDGES) begin
						next_power_mode = sarro_pkg::SARRO_PWR_PARTIAL;
					end
				end
			end
		end else if (sel_fall) begin
			// Sample, hold and present first leading zero
			next_held_level = analog_level;
			next_tracking = 1'b0;
			next_frame_active = 1'b1;
			next_edge_cnt = '0;
			next_dout_oe = 1'b1;
			next_dout = 1'b0;
			next_waking = (power_mode != sarro_pkg::SARRO_PWR_NORMAL);
			// Wake frames shift zeros only and give no result
			if (power_mode != sarro_pkg::SARRO_PWR_NORMAL) begin
				next_shreg = '0;
			end else begin
				next_shreg = {{sarro_pkg::LEAD_ZEROS{1'b0}}, analog_level,
					{TRAIL_ZEROS{1'b0}}};
			end
		end else if (frame_active && sck_fall && edge_cnt != sarro_pkg::FRAME_EDGES) begin
			// Each serial clock fall up to the sixteenth advances conversion and shifts a bit
			next_edge_cnt = edge_inc;
			next_shreg = {shreg[sarro_pkg::FRAME_BITS-2:0], 1'b0};
			next_dout = shreg[sarro_pkg::FRAME_BITS-2];
			if (edge_inc == sarro_pkg::FRAME_EDGES) begin
				next_dout_oe = 1'b0;
				if (waking) begin
					next_waking = 1'b0;
					next_power_mode = sarro_pkg::SARRO_PWR_NORMAL;
				end
			end
			if (edge_inc == CONV_EDGES && !waking) begin
				next_result_data = held_level;
				next_result_valid = 1'b1;
			end
		end else if (frame_active && sck_rise && !tracking && edge_cnt >= TRACK_EDGES) begin
			// Rising edge after fall RES_BITS+1, one fall before the result, returns to track
			next_tracking = 1'b1;
		end
	end

	// Frame state registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shreg <= '0;
			edge_cnt <= '0;
			held_level <= '0;
			waking <= 1'b0;
			dout <= 1'b0;
			dout_oe <= 1'b0;
			frame_active <= 1'b0;
			tracking <= 1'b1;
			result_data <= '0;
			result_valid <= 1'b0;
			power_mode <= sarro_pkg::SARRO_PWR_NORMAL;
		end else begin
			shreg <= next_shreg;
			edge_cnt <= next_edge_cnt;
			held_level <= next_held_level;
			waking <= next_waking;
			dout <= next_dout;
			dout_oe <= next_dout_oe;
			frame_active <= next_frame_active;
			tracking <= next_tracking;
			result_data <= next_result_data;
			result_valid <= next_result_valid;
			power_mode <= next_power_mode;
		end
	end

	// Line drive straight from flops
	assign link.serial_result_out = dout;
	assign link.serial_result_oe = dout_oe;
endmodule // sarro_adc_end
`default_nettype wire

// ---- sarro_host_end.sv ----
// Host end: makes select and serial clock, captures frames on falling edges
`timescale 1ns/10ps
`default_nettype none
module sarro_host_end (
	input wire logic clk,
	input wire logic rst_b,
	sarro_link_if.host link,
	input wire logic start,
	input wire logic [sarro_pkg::CNT_W-1:0] frame_edges,
	output logic busy,
	output logic [sarro_pkg::FRAME_BITS-1:0] rx_word,
	output logic rx_valid
);
	typedef enum logic [1:0] {
		SARRO_H_IDLE,
		SARRO_H_LEAD,
		SARRO_H_RUN,
		SARRO_H_QUIET
	} sarro_hstate_type;

	// Data line passes two flops
	logic din_s1;
	logic din_s2;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			din_s1 <= 1'b1;
			din_s2 <= 1'b1;
		end else begin
			din_s1 <= link.line_level;
			din_s2 <= din_s1;
		end
	end

	sarro_hstate_type state;
	sarro_hstate_type next_state;
	logic [sarro_pkg::DIV_W-1:0] div;
	logic [sarro_pkg::DIV_W-1:0] next_div;
	logic [sarro_pkg::CNT_W-1:0] cnt;
	logic [sarro_pkg::CNT_W-1:0] next_cnt;
	logic [sarro_pkg::CNT_W-1:0] len;
	logic [sarro_pkg::CNT_W-1:0] next_len;
	logic [sarro_pkg::FRAME_BITS-1:0] word;
	logic [sarro_pkg::FRAME_BITS-1:0] next_word;
	logic sel_b;
	logic next_sel_b;
	logic sck;
	logic next_sck;
	logic next_busy;
	logic [sarro_pkg::FRAME_BITS-1:0] next_rx_word;
	logic next_rx_valid;

	// Frame sequencer with clock divider
	always_comb begin
		next_state = state;
		next_div = div;
		next_cnt = cnt;
		next_len = len;
		next_word = word;
		next_sel_b = sel_b;
		next_sck = sck;
		next_busy = busy;
		next_rx_word = rx_word;
		next_rx_valid = 1'b0;
		if (state != SARRO_H_IDLE && div != '0) begin
			next_div = div - sarro_pkg::DIV_W'(1);
		end else begin
			case (state)
				SARRO_H_IDLE: begin
					if (start && frame_edges != '0) begin
						next_sel_b = 1'b0;
						next_len = frame_edges;
						next_cnt = '0;
						next_word = '0;
						next_busy = 1'b1;
						// Full period lead: first zero must clear both syncs
						next_div = sarro_pkg::LEAD_CYCLES - sarro_pkg::DIV_W'(1);
						next_state = SARRO_H_LEAD;
					end
				end
				SARRO_H_LEAD: begin
					// First fall captures the leading zero
					next_sck = 1'b0;
					next_word = {word[sarro_pkg::FRAME_BITS-2:0], din_s2};
					next_cnt = sarro_pkg::CNT_W'(1);
					next_div = sarro_pkg::HALF_CYCLES - sarro_pkg::DIV_W'(1);
					next_state = SARRO_H_RUN;
				end
				SARRO_H_RUN: begin
					next_div = sarro_pkg::HALF_CYCLES - sarro_pkg::DIV_W'(1);
					if (!sck) begin
						next_sck = 1'b1;
						if (cnt == len) begin
							// Select rises on the rise after the last fall
							next_sel_b = 1'b1;
							next_rx_word = word;
							next_rx_valid = 1'b1;
							next_div = sarro_pkg::QUIET_CYCLES - sarro_pkg::DIV_W'(1);
							next_state = SARRO_H_QUIET;
						end
					end else begin
						next_sck = 1'b0;
						next_word = {word[sarro_pkg::FRAME_BITS-2:0], din_s2};
						next_cnt = cnt + sarro_pkg::CNT_W'(1);
					end
				end
				default: begin
					next_busy = 1'b0;
					next_state = SARRO_H_IDLE;
				end
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= SARRO_H_IDLE;
			div <= '0;
			cnt <= '0;
			len <= '0;
			word <= '0;
			sel_b <= 1'b1;
			sck <= 1'b1;
			busy <= 1'b0;
			rx_word <= '0;
			rx_valid <= 1'b0;
		end else begin
			state <= next_state;
			div <= next_div;
			cnt <= next_cnt;
			len <= next_len;
			word <= next_word;
			sel_b <= next_sel_b;
			sck <= next_sck;
			busy <= next_busy;
			rx_word <= next_rx_word;
			rx_valid <= next_rx_valid;
		end
	end

	assign link.conv_sel_b = sel_b;
	assign link.ser_clk = sck;
endmodule // sarro_host_end
`default_nettype wire

// ---- sarro_assertions.sv ----
// Timing checks on the link between converter end and host end
`timescale 1ns/10ps
`default_nettype none
module sarro_assertions #(
	parameter int unsigned RES_BITS = 12
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic conv_sel_b,
	input wire logic ser_clk,
	input wire logic serial_result_out,
	input wire logic serial_result_oe
);
	logic ser_q, next_ser_q;
	logic [4:0] fall_cnt, next_fall_cnt;
	logic [1:0] since, next_since;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Count clock falls in a frame, and cycles since the last one
	always_comb begin
		next_ser_q = ser_clk;
		next_fall_cnt = conv_sel_b ? 5'h00 : fall_cnt;
		next_since = (since == 2'h3) ? since : since + 2'h1;
		if (ser_q && !ser_clk && !conv_sel_b) begin
			next_fall_cnt = fall_cnt + 5'h01;
			next_since = 2'h0;
		end
	end
	// Helper registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ser_q <= 1'b1;
			fall_cnt <= 5'h00;
			since <= 2'h0;
		end else begin
			ser_q <= next_ser_q;
			fall_cnt <= next_fall_cnt;
			since <= next_since;
		end
	end
	sequence s_lead;
		ser_clk[*8] ##1 !ser_clk;
	endsequence
	sequence s_low_half;
		(!ser_clk)[*4] ##1 ser_clk;
	endsequence
	property p_take;
		$fell(conv_sel_b) |-> ##[1:4] (serial_result_oe && !serial_result_out);
	endproperty
	a_take: assert property (p_take) else $error("select fall gave no driven zero");
	property p_abort;
		$rose(conv_sel_b) |-> ##[1:4] !serial_result_oe;
	endproperty
	a_abort: assert property (p_abort) else $error("line kept after select rise");
	property p_idle_rel;
		conv_sel_b[*5] |-> !serial_result_oe;
	endproperty
	a_idle_rel: assert property (p_idle_rel) else $error("line driven while idle");
	property p_lead_zero;
		(!conv_sel_b && serial_result_oe && fall_cnt <= 5'h01) |-> !serial_result_out;
	endproperty
	a_lead_zero: assert property (p_lead_zero) else $error("leading bit not zero");
	property p_trail;
		(!conv_sel_b && fall_cnt >= RES_BITS + 2 && since == 2'h3) |-> !serial_result_out;
	endproperty
	a_trail: assert property (p_trail) else $error("trailing bit not zero");
	property p_release16;
		($rose(conv_sel_b) && fall_cnt == 5'h10) |-> !serial_result_oe;
	endproperty
	a_release16: assert property (p_release16) else $error("line kept after last fall");
	property p_lead;
		$fell(conv_sel_b) |-> s_lead;
	endproperty
	a_lead: assert property (p_lead) else $error("first clock fall misplaced");
	property p_half;
		$fell(ser_clk) |-> s_low_half;
	endproperty
	a_half: assert property (p_half) else $error("clock low phase wrong");
	property p_idle_clk;
		conv_sel_b |-> ser_clk;
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("clock low outside frame");
	property p_rise_hold;
		($rose(ser_clk) && !conv_sel_b) |-> $stable(serial_result_out);
	endproperty
	a_rise_hold: assert property (p_rise_hold) else $error("data moved at clock rise");
endmodule // sarro_assertions
`default_nettype wire

// ---- sarro_test.sv ----
// Testbench: both link ends joined, frames run from the host command port
`timescale 1ns/10ps
`default_nettype none
module sarro_test;
	localparam int unsigned RES = 12;
	logic clk, rst_b, start, busy, rx_valid, result_valid, tracking, frame_active;
	logic [sarro_pkg::CNT_W-1:0] frame_edges;
	logic [15:0] rx_word;
	logic [RES-1:0] analog_level, result_data;
	sarro_pkg::sarro_power_type power_mode;
	int err_total = 0;
	int tests_run = 0;
	int valid_cnt = 0;
	int hold_cnt = 0;
	// Hold time: lead, RES_BITS+1 falls, then half a period to the rise
	localparam int HOLD_CYCLES =
		int'(sarro_pkg::LEAD_CYCLES) + (2 * RES + 1) * int'(sarro_pkg::HALF_CYCLES);
	sarro_link_if link();
	sarro_host_end u_sarro_host_end (.clk(clk), .rst_b(rst_b), .link(link), .start(start),
		.frame_edges(frame_edges), .busy(busy), .rx_word(rx_word), .rx_valid(rx_valid));
	sarro_adc_end #(.RES_BITS(RES)) u_sarro_adc_end (.clk(clk), .rst_b(rst_b), .link(link),
		.analog_level(analog_level), .result_data(result_data), .result_valid(result_valid),
		.tracking(tracking), .frame_active(frame_active), .power_mode(power_mode));
	sarro_assertions #(.RES_BITS(RES)) u_sarro_assertions (.clk(clk), .rst_b(rst_b),
		.conv_sel_b(link.conv_sel_b), .ser_clk(link.ser_clk),
		.serial_result_out(link.serial_result_out), .serial_result_oe(link.serial_result_oe));
	// Clock and result pulse count
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		if (result_valid === 1'b1) valid_cnt++;
		if (tracking === 1'b0) hold_cnt++;
	end
	task automatic summarize();
		if (err_total == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One host frame of n falls, then checks of word, power state and pulses
	task automatic run(input logic [4:0] n, input logic [RES-1:0] lvl, input bit wake,
		input sarro_pkg::sarro_power_type pwr, input int vld);
		int i;
		int v0;
		int h0;
		logic [15:0] exp;
		v0 = valid_cnt;
		h0 = hold_cnt;
		exp = wake ? 16'h0000 : 16'({2'b00, lvl, 2'b00} >> (5'h10 - n));
		analog_level = lvl;
		frame_edges = n;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		for (i = 0; i < 300 && rx_valid !== 1'b1; i++) @(negedge clk);
		if (rx_valid !== 1'b1) begin
			err_total++;
			summarize();
		end
		for (i = 0; i < 300 && busy !== 1'b0; i++) @(negedge clk);
		if (busy !== 1'b0) begin
			err_total++;
			summarize();
		end
		repeat (3) @(negedge clk);
		chk("rx_word", rx_word, exp);
		chk("power_mode", 16'(power_mode), 16'(pwr));
		chk("result_valid", 16'(valid_cnt - v0), 16'(vld));
		chk("idle_lines", 16'({link.ser_clk, link.line_level}), 16'h0003);
		if (vld == 1) chk("result_data", 16'(result_data), 16'(lvl));
		if (vld == 1) chk("hold_cycles", 16'(hold_cnt - h0), 16'(HOLD_CYCLES));
		chk("idle_state", 16'({tracking, frame_active}), 16'h0002);
	endtask
	// Reset, then frames of several lengths and one power-down and wake sequence
	initial begin
		rst_b = 1'b0;
		start = 1'b0;
		frame_edges = 5'h10;
		analog_level = 12'h000;
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		run(5'h10, 12'ha5c, 1'b0, sarro_pkg::SARRO_PWR_NORMAL, 1);
		run(5'h10, 12'h5a3, 1'b0, sarro_pkg::SARRO_PWR_NORMAL, 1);
		run(5'h0e, 12'h3c9, 1'b0, sarro_pkg::SARRO_PWR_NORMAL, 1);
		run(5'h0d, 12'hfff, 1'b0, sarro_pkg::SARRO_PWR_NORMAL, 0);
		run(5'h01, 12'hfff, 1'b0, sarro_pkg::SARRO_PWR_NORMAL, 0);
		run(5'h08, 12'hfff, 1'b0, sarro_pkg::SARRO_PWR_PARTIAL, 0);
		run(5'h05, 12'h0f0, 1'b1, sarro_pkg::SARRO_PWR_FULL, 0);
		run(5'h10, 12'h123, 1'b1, sarro_pkg::SARRO_PWR_NORMAL, 0);
		run(5'h10, 12'h801, 1'b0, sarro_pkg::SARRO_PWR_NORMAL, 1);
		summarize();
	end
endmodule // sarro_test
`default_nettype wire
